/* design/pcsr_page_control_status_regs.sv */
// Two-wire slave holding the page control register and serving the live status registers.
// Summary of operation
// - With auto-return set, page select goes back to zero when an access that did not write page control finishes.
// - Bit 6 picks page write (0) or repeated write (1) for multi-byte writes.
// - Page select 0,1,2 maps 0x01-0x3F, 0x81-0xCF, 0x101-0x13F; 3 is test only.
// - Page control answers at local offset zero of every page.
// - Each control interface owns its own page control copy.
// - Status reads return present signal levels, never latched values.
// - Status bits keep the polarity of the signal they mirror, except misc bit 0, which inverts the power key pin.
// - Misc status bit 3 shows the supply comparator output.
// - Misc status bit 2 is one while any supply ramp is still running.
// - Misc bit 0 is one while power key is low; bit 1 mirrors charger wake.
// - Inputs-low register shows inputs 7-0, or analogue high-threshold flags on bits 2-0.
// - Limit register bits 7,6,5,3 show regulators 11,8,7,3 in current limit.
`include "pcsr_regs.svh"
module pcsr_page_control_status_regs import pcsr_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = `PCSR_DEV_ADDR_DEFAULT
) (
	input wire logic core_clk_i, // System clock, 50 MHz.
	input wire logic sys_rst_i, // Asynchronous reset, active high.
	input wire logic scl_i, // Bus clock pin level.
	input wire logic sda_i, // Bus data pin level.
	output logic sda_o, // Bus data drive value.
	output logic sda_oe_n_o, // Bus data enable, low while driving.
	input wire logic supply_comparator_state_i, // Supply comparator output.
	input wire logic voltage_ramp_active_i, // Any supply ramp running.
	input wire logic charger_wake_input_i, // Charger wake pin level.
	input wire logic power_key_n_i, // Power key pin, low when pressed.
	input wire logic [15:0] general_input_i, // General input pin levels.
	input wire logic [3:0] regulator_limit_i, // Limits of regulators 11,8,7,3.
	input wire logic [2:0] analog_mode_i, // Inputs 0-2 serve analogue channels.
	input wire logic [2:0] analog_high_i, // Analogue high-threshold flags.
	output logic [2:0] page_select_o, // Current page select.
	output logic repeated_write_o, // Repeated write mode active.
	output logic page_auto_return_o // Auto-return enabled.
);

	// ==========================================================================
	// Input synchronisation
	// ==========================================================================
	localparam pcsr_status_s STATUS_RST = '{power_key_n: 1'b1, default: '0};
	pcsr_status_s status_raw;
	pcsr_status_s status_sync;
	logic [1:0] bus_sync;
	logic scl_f;
	logic sda_f;

	always_comb begin
		status_raw.supply_comparator_state = supply_comparator_state_i;
		status_raw.voltage_ramp_active = voltage_ramp_active_i;
		status_raw.charger_wake_input = charger_wake_input_i;
		status_raw.power_key_n = power_key_n_i;
		status_raw.general_input = general_input_i;
		status_raw.regulator_limit = regulator_limit_i;
	end

	pcsr_sync #(
		.W($bits(pcsr_status_s)),
		.RST(STATUS_RST)
	) u_status_sync (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.d_i(status_raw),
		.q_o(status_sync)
	);

	pcsr_sync #(
		.W(2),
		.RST(2'h3)
	) u_bus_sync (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.d_i({scl_i, sda_i}),
		.q_o(bus_sync)
	);

	assign scl_f = bus_sync[1];
	assign sda_f = bus_sync[0];

	// ==========================================================================
	// Bus conditions
	// ==========================================================================
	logic scl_prev;
	logic sda_prev;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_prev <= scl_f;
			sda_prev <= sda_f;
		end
	end

	assign scl_rise = scl_f & ~scl_prev;
	assign scl_fall = ~scl_f & scl_prev;
	assign bus_start = scl_f & scl_prev & sda_prev & ~sda_f;
	assign bus_stop = scl_f & scl_prev & ~sda_prev & sda_f;

	// ==========================================================================
	// Register read decode
	// ==========================================================================
	logic [7:0] page_control;
	logic [7:0] ptr;
	logic status_hit;
	logic [7:0] status_data;
	logic [7:0] rd_data;

	pcsr_status u_status (
		.status_i(status_sync),
		.analog_mode_i(analog_mode_i),
		.analog_high_i(analog_high_i),
		.page_i(page_control[`PCSR_PAGE_MSB:`PCSR_PAGE_LSB]),
		.local_i(ptr[6:0]),
		.hit_o(status_hit),
		.data_o(status_data)
	);

	// Offset bit 7 is dropped: 0x80 lands on local zero, so page control answers in every page.
	always_comb begin
		if (ptr[6:0] == `PCSR_OFS_PAGE_CONTROL) begin
			rd_data = page_control;
		end else if (status_hit) begin
			rd_data = status_data;
		end else begin
			rd_data = `PCSR_READ_ZERO;
		end
	end

	// ==========================================================================
	// Two-wire slave
	// ==========================================================================
	pcsr_state_e state;
	logic [3:0] bit_cnt;
	logic [7:0] rx;
	logic [7:0] tx;
	logic rd_acked;
	logic accessed;
	logic pc_written;
	logic wr_en;
	logic [6:0] wr_local;
	logic [7:0] wr_data;
	logic access_end;

	assign access_end = (bus_start | bus_stop) & accessed;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			rx <= 8'h00;
			tx <= 8'h00;
			ptr <= 8'h00;
			rd_acked <= 1'b0;
			sda_oe_n_o <= 1'b1;
			wr_en <= 1'b0;
			wr_local <= 7'h00;
			wr_data <= 8'h00;
		end else begin
			wr_en <= 1'b0;
			if (bus_start) begin
				state <= ST_DEV;
				bit_cnt <= 4'h0;
				sda_oe_n_o <= 1'b1;
			end else if (bus_stop) begin
				state <= ST_IDLE;
				sda_oe_n_o <= 1'b1;
			end else if (scl_rise) begin
				case (state)
					ST_DEV, ST_REG, ST_WR, ST_RD: begin
						rx <= {rx[6:0], sda_f};
						bit_cnt <= bit_cnt + 4'h1;
					end
					ST_RD_ACK: begin
						rd_acked <= ~sda_f;
						// Step on here so the next byte is settled by the fall.
						if (!sda_f) begin
							ptr <= ptr + 8'h01;
						end
					end
					default: ;
				endcase
			end else if (scl_fall) begin
				case (state)
					ST_DEV: begin
						if (bit_cnt == `PCSR_BYTE_BITS) begin
							if (rx[7:1] == DEV_ADDR) begin
								state <= ST_DEV_ACK;
								sda_oe_n_o <= 1'b0;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					ST_DEV_ACK: begin
						bit_cnt <= 4'h0;
						if (rx[0]) begin
							// Status is sampled here, at the moment the host starts the byte.
							tx <= rd_data;
							sda_oe_n_o <= rd_data[7];
							state <= ST_RD;
						end else begin
							sda_oe_n_o <= 1'b1;
							state <= ST_REG;
						end
					end
					ST_REG: begin
						if (bit_cnt == `PCSR_BYTE_BITS) begin
							ptr <= rx;
							sda_oe_n_o <= 1'b0;
							state <= ST_REG_ACK;
						end
					end
					ST_REG_ACK: begin
						bit_cnt <= 4'h0;
						sda_oe_n_o <= 1'b1;
						state <= ST_WR;
					end
					ST_WR: begin
						if (bit_cnt == `PCSR_BYTE_BITS) begin
							wr_en <= 1'b1;
							wr_local <= ptr[6:0];
							wr_data <= rx;
							sda_oe_n_o <= 1'b0;
							state <= ST_WR_ACK;
						end
					end
					ST_WR_ACK: begin
						bit_cnt <= 4'h0;
						sda_oe_n_o <= 1'b1;
						if (repeated_write_o) begin
							state <= ST_REG;
						end else begin
							ptr <= ptr + 8'h01;
							state <= ST_WR;
						end
					end
					ST_RD: begin
						if (bit_cnt == `PCSR_BYTE_BITS) begin
							sda_oe_n_o <= 1'b1;
							state <= ST_RD_ACK;
						end else begin
							tx <= {tx[6:0], 1'b0};
							sda_oe_n_o <= tx[6];
						end
					end
					ST_RD_ACK: begin
						bit_cnt <= 4'h0;
						if (rd_acked) begin
							tx <= rd_data;
							sda_oe_n_o <= rd_data[7];
							state <= ST_RD;
						end else begin
							state <= ST_IDLE;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// A zero bit is sent by enabling the driver; a one is sent by releasing the line.
	assign sda_o = `PCSR_SDA_DRIVE;

	// ==========================================================================
	// Access bookkeeping for auto-return
	// ==========================================================================
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			accessed <= 1'b0;
			pc_written <= 1'b0;
		end else if (bus_start | bus_stop) begin
			accessed <= 1'b0;
			pc_written <= 1'b0;
		end else begin
			if (state == ST_DEV_ACK) begin
				accessed <= 1'b1;
			end
			if (wr_en && wr_local == `PCSR_OFS_PAGE_CONTROL) begin
				pc_written <= 1'b1;
			end
		end
	end

	// ==========================================================================
	// Page control register
	// ==========================================================================
	// This module is one control interface; a second interface instantiates its own copy.
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			page_control <= `PCSR_PAGE_CONTROL_RESET;
		end else if (wr_en && wr_local == `PCSR_OFS_PAGE_CONTROL) begin
			page_control <= wr_data & `PCSR_PAGE_CONTROL_WMASK;
		end else if (access_end && !pc_written && page_control[`PCSR_BIT_AUTO_RETURN]) begin
			// The access that sets up a page is spared, or the setting could never be used.
			page_control[`PCSR_PAGE_MSB:`PCSR_PAGE_LSB] <= `PCSR_PAGE_0;
		end
	end

	assign page_select_o = page_control[`PCSR_PAGE_MSB:`PCSR_PAGE_LSB];
	assign repeated_write_o = page_control[`PCSR_BIT_WRITE_MODE];
	assign page_auto_return_o = page_control[`PCSR_BIT_AUTO_RETURN];

endmodule

/* design/pcsr_status.sv */
// Live status register read decode for page 0.
`include "pcsr_regs.svh"
module pcsr_status import pcsr_pkg::*; (
	input wire pcsr_status_s status_i, // Synchronised monitored levels.
	input wire logic [2:0] analog_mode_i, // Pin serves analogue input when high.
	input wire logic [2:0] analog_high_i, // Analogue input above high threshold.
	input wire logic [2:0] page_i, // Current page select.
	input wire logic [6:0] local_i, // Local register offset.
	output logic hit_o, // Offset maps to a status register.
	output logic [7:0] data_o // Read value, reserved bits zero.
);

	// ==========================================================================
	// Assembly of each register from present levels
	// ==========================================================================
	logic [7:0] misc;
	logic [7:0] inputs_low;
	logic [7:0] limits;

	always_comb begin
		misc = `PCSR_READ_ZERO;
		misc[`PCSR_BIT_COMPARATOR] = status_i.supply_comparator_state;
		misc[`PCSR_BIT_RAMP] = status_i.voltage_ramp_active;
		misc[`PCSR_BIT_WAKE] = status_i.charger_wake_input;
		misc[`PCSR_BIT_KEY] = ~status_i.power_key_n;
		inputs_low = status_i.general_input[7:0];
		for (int k = 0; k < 3; k++) begin
			if (analog_mode_i[k]) begin
				inputs_low[k] = analog_high_i[k];
			end
		end
		limits = `PCSR_READ_ZERO;
		limits[`PCSR_BIT_LIM_REG11] = status_i.regulator_limit[3];
		limits[`PCSR_BIT_LIM_REG8] = status_i.regulator_limit[2];
		limits[`PCSR_BIT_LIM_REG7] = status_i.regulator_limit[1];
		limits[`PCSR_BIT_LIM_REG3] = status_i.regulator_limit[0];
	end

	always_comb begin
		hit_o = (page_i == `PCSR_PAGE_0);
		data_o = `PCSR_READ_ZERO;
		case (local_i)
			`PCSR_OFS_STATUS_MISC: data_o = misc;
			`PCSR_OFS_STATUS_INPUTS_LOW: data_o = inputs_low;
			`PCSR_OFS_STATUS_INPUTS_HIGH: data_o = status_i.general_input[15:8];
			`PCSR_OFS_STATUS_LIMITS: data_o = limits;
			default: hit_o = 1'b0;
		endcase
	end

endmodule

/* design/pcsr_sync.sv */
// Three-stage input synchroniser with an agreement filter on the last two stages.
module pcsr_sync import pcsr_pkg::*; #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic core_clk_i, // System clock.
	input wire logic sys_rst_i, // Asynchronous reset, active high.
	input wire logic [W-1:0] d_i, // Asynchronous inputs.
	output logic [W-1:0] q_o // Filtered, synchronous copies.
);

	// ==========================================================================
	// Per-bit chain
	// ==========================================================================
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					s1 <= RST[i];
					s2 <= RST[i];
					s3 <= RST[i];
					q_o[i] <= RST[i];
				end else begin
					s1 <= d_i[i];
					s2 <= s1;
					s3 <= s2;
					// A change is accepted only once two stages agree, so one-cycle glitches vanish.
					if (s2 == s3) begin
						q_o[i] <= s3;
					end
				end
			end
		end
	endgenerate

endmodule

/* shared/pcsr_pkg.sv */
// Types shared by the page control and live status block.
package pcsr_pkg;

	// ==========================================================================
	// Monitored signals, one bundle so they synchronise together
	// ==========================================================================
	typedef struct packed {
		logic supply_comparator_state;
		logic voltage_ramp_active;
		logic charger_wake_input;
		logic power_key_n;
		logic [15:0] general_input;
		logic [3:0] regulator_limit;
	} pcsr_status_s;

	// ==========================================================================
	// Two-wire slave states
	// ==========================================================================
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_DEV,
		ST_DEV_ACK,
		ST_REG,
		ST_REG_ACK,
		ST_WR,
		ST_WR_ACK,
		ST_RD,
		ST_RD_ACK
	} pcsr_state_e;

endpackage

/* shared/pcsr_regs.svh */
// Register map, field positions, reset values and bus constants for the page control block.
`ifndef PCSR_REGS_SVH
`define PCSR_REGS_SVH

// ==========================================================================
// Local offsets within a page
// ==========================================================================
`define PCSR_OFS_PAGE_CONTROL 7'h00
`define PCSR_OFS_STATUS_MISC 7'h01
`define PCSR_OFS_STATUS_INPUTS_LOW 7'h02
`define PCSR_OFS_STATUS_INPUTS_HIGH 7'h03
`define PCSR_OFS_STATUS_LIMITS 7'h04

// ==========================================================================
// Page control fields
// ==========================================================================
`define PCSR_PAGE_CONTROL_RESET 8'h00
`define PCSR_PAGE_CONTROL_WMASK 8'hc7
`define PCSR_BIT_AUTO_RETURN 7
`define PCSR_BIT_WRITE_MODE 6
`define PCSR_PAGE_MSB 2
`define PCSR_PAGE_LSB 0
`define PCSR_PAGE_0 3'h0
`define PCSR_PAGE_1 3'h1
`define PCSR_PAGE_2 3'h2
`define PCSR_PAGE_TEST 3'h3

// ==========================================================================
// Status field positions
// ==========================================================================
`define PCSR_BIT_COMPARATOR 3
`define PCSR_BIT_RAMP 2
`define PCSR_BIT_WAKE 1
`define PCSR_BIT_KEY 0
`define PCSR_BIT_LIM_REG11 7
`define PCSR_BIT_LIM_REG8 6
`define PCSR_BIT_LIM_REG7 5
`define PCSR_BIT_LIM_REG3 3
`define PCSR_READ_ZERO 8'h00

// ==========================================================================
// Two-wire bus
// ==========================================================================
`define PCSR_DEV_ADDR_DEFAULT 7'h58
`define PCSR_BYTE_BITS 4'h8
`define PCSR_SDA_DRIVE 1'b0

`endif

/* tb/pcsr_host_model.sv */
// Two-wire bus host model that drives the clock and releases or pulls the data line.
`include "pcsr_regs.svh"
module pcsr_host_model import pcsr_pkg::*; #(
	parameter int Q = 6,
	parameter logic [6:0] DEV_ADDR = `PCSR_DEV_ADDR_DEFAULT
) (
	input wire logic core_clk_i, // System clock.
	input wire logic sda_i, // Resolved data line level.
	output logic scl_o, // Bus clock level.
	output logic sda_drv_o // Low pulls the data line low.
);
	initial begin
		scl_o = 1'b1;
		sda_drv_o = 1'b1;
	end
	// ==========================================================================
	// Bit and byte level
	// ==========================================================================
	task automatic qwait(input int n);
		repeat (n * Q) @(posedge core_clk_i);
	endtask
	// Data moves only while the clock is low, so no false start or stop appears.
	task automatic put_bit(input logic b);
		qwait(1);
		sda_drv_o <= b;
		qwait(1);
		scl_o <= 1'b1;
		qwait(2);
		scl_o <= 1'b0;
	endtask
	task automatic get_bit(output logic b);
		qwait(1);
		sda_drv_o <= 1'b1;
		qwait(1);
		scl_o <= 1'b1;
		qwait(1);
		b = sda_i;
		qwait(1);
		scl_o <= 1'b0;
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		get_bit(b);
		ack = ~b;
	endtask
	task automatic recv_byte(input logic more, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(~more);
	endtask
	task automatic start_cond();
		qwait(1);
		sda_drv_o <= 1'b1;
		qwait(1);
		scl_o <= 1'b1;
		qwait(1);
		sda_drv_o <= 1'b0;
		qwait(1);
		scl_o <= 1'b0;
	endtask
	task automatic stop_cond();
		qwait(1);
		sda_drv_o <= 1'b0;
		qwait(1);
		scl_o <= 1'b1;
		qwait(1);
		sda_drv_o <= 1'b1;
		qwait(3);
	endtask
	// ==========================================================================
	// Frames
	// ==========================================================================
	// Sends nbytes bytes from the top of data; ok is high only if every byte was acknowledged.
	task automatic write_frame(input logic [7:0] addr_byte, input logic [31:0] data,
			input int nbytes, output logic ok);
		logic a;
		start_cond();
		send_byte(addr_byte, ok);
		for (int i = 0; i < nbytes; i++) begin
			send_byte(data[31 - 8 * i -: 8], a);
			ok = ok & a;
		end
		stop_cond();
	endtask
	task automatic read_reg(input logic [7:0] offset, output logic [7:0] d);
		logic a;
		start_cond();
		send_byte({DEV_ADDR, 1'b0}, a);
		send_byte(offset, a);
		start_cond();
		send_byte({DEV_ADDR, 1'b1}, a);
		recv_byte(1'b0, d);
		stop_cond();
	endtask
	// Two bytes in one read; the first is acknowledged so the offset steps on.
	task automatic read_pair(input logic [7:0] offset, output logic [15:0] d);
		logic a;
		start_cond();
		send_byte({DEV_ADDR, 1'b0}, a);
		send_byte(offset, a);
		start_cond();
		send_byte({DEV_ADDR, 1'b1}, a);
		recv_byte(1'b1, d[15:8]);
		recv_byte(1'b0, d[7:0]);
		stop_cond();
	endtask
endmodule

/* tb/pcsr_page_control_status_regs_props.sv */
// Concurrent checks on the ports of the page control and live status block.
module pcsr_page_control_status_regs_props import pcsr_pkg::*; (
	input wire logic core_clk_i, // System clock.
	input wire logic sys_rst_i, // Asynchronous reset.
	input wire logic scl_i, // Bus clock pin.
	input wire logic sda_i, // Bus data pin.
	input wire logic sda_o, // Drive value.
	input wire logic sda_oe_n_o, // Drive enable, low active.
	input wire logic [2:0] page_select_o, // Page select.
	input wire logic repeated_write_o, // Repeated write mode.
	input wire logic page_auto_return_o // Auto-return enable.
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	chk_reset_config: assert property (
		$fell(sys_rst_i) |-> {page_auto_return_o, repeated_write_o, page_select_o} == 5'h00)
		else $error("configuration not clear after reset");
	// Writes land while the clock is low, so a page change with the clock high is a return.
	chk_return_zero: assert property (
		$changed(page_select_o) && scl_i |-> page_select_o == 3'h0 && page_auto_return_o)
		else $error("page changed at bus end without auto-return");
	chk_return_keeps_mode: assert property (
		$changed(page_select_o) && scl_i |->
			$stable(repeated_write_o) && $stable(page_auto_return_o))
		else $error("page return disturbed mode bits");
	chk_mode_scl_low: assert property (
		$changed({repeated_write_o, page_auto_return_o}) |-> !scl_i)
		else $error("mode bits changed outside a data byte");
	chk_mode_acked: assert property (
		$changed(repeated_write_o) |-> ##[0:8] !sda_oe_n_o)
		else $error("write mode changed without an acknowledged byte");
	chk_drive_scl_low: assert property (
		$changed(sda_oe_n_o) |-> !scl_i)
		else $error("data drive changed while clock high");
	chk_drive_value: assert property (
		!sda_oe_n_o |-> sda_o == 1'b0)
		else $error("data line driven high");
	chk_drive_hold: assert property (
		$fell(sda_oe_n_o) |=> !sda_oe_n_o [*8])
		else $error("driven bit released too early");
	chk_idle_stable: assert property (
		(scl_i && sda_i) [*8] |=> $stable(page_select_o))
		else $error("page changed on an idle bus");
endmodule

bind pcsr_page_control_status_regs pcsr_page_control_status_regs_props u_props (
	.core_clk_i(core_clk_i),
	.sys_rst_i(sys_rst_i),
	.scl_i(scl_i),
	.sda_i(sda_i),
	.sda_o(sda_o),
	.sda_oe_n_o(sda_oe_n_o),
	.page_select_o(page_select_o),
	.repeated_write_o(repeated_write_o),
	.page_auto_return_o(page_auto_return_o)
);

/* tb/test_page_control_status_regs.sv */
// Self-checking bench for the page control and live status block.
`include "pcsr_regs.svh"
module test_page_control_status_regs import pcsr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ADDR_W = {`PCSR_DEV_ADDR_DEFAULT, 1'b0};
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic comp_in = 1'b0;
	logic ramp_in = 1'b0;
	logic wake_in = 1'b0;
	logic key_n_in = 1'b1;
	logic [15:0] gpi_in = 16'h0000;
	logic [3:0] lim_in = 4'h0;
	logic [2:0] amode_in = 3'h0;
	logic [2:0] ahigh_in = 3'h0;
	wire logic scl_line;
	wire logic sda_drv;
	wire logic sda_line;
	wire logic sda_out;
	wire logic sda_oe_n;
	wire logic [2:0] cfg_page;
	wire logic cfg_rep;
	wire logic cfg_ret;
	int num_errors = 0;
	int total_checks = 0;
	always #10 core_clk_i = ~core_clk_i;
	// The line is pulled up, so either party pulling low wins.
	assign sda_line = sda_drv & (sda_oe_n | sda_out);
	pcsr_page_control_status_regs dut (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.scl_i(scl_line),
		.sda_i(sda_line),
		.sda_o(sda_out),
		.sda_oe_n_o(sda_oe_n),
		.supply_comparator_state_i(comp_in),
		.voltage_ramp_active_i(ramp_in),
		.charger_wake_input_i(wake_in),
		.power_key_n_i(key_n_in),
		.general_input_i(gpi_in),
		.regulator_limit_i(lim_in),
		.analog_mode_i(amode_in),
		.analog_high_i(ahigh_in),
		.page_select_o(cfg_page),
		.repeated_write_o(cfg_rep),
		.page_auto_return_o(cfg_ret)
	);
	pcsr_host_model host (
		.core_clk_i(core_clk_i),
		.sda_i(sda_line),
		.scl_o(scl_line),
		.sda_drv_o(sda_drv)
	);
	// ==========================================================================
	// Checks and bus access
	// ==========================================================================
	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_bit(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask
	// The outputs rebuilt in register layout, with the unused bits zero.
	function automatic logic [7:0] cfg();
		return {cfg_ret, cfg_rep, 3'h0, cfg_page};
	endfunction
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		logic ok;
		host.write_frame(ADDR_W, {ofs, d, 16'h0000}, 2, ok);
		check_bit("write ack", 1'b1, ok);
	endtask
	task automatic rd_chk(input string what, input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] d;
		host.read_reg(ofs, d);
		check_byte(what, exp, d);
	endtask
	// Misc inputs are given as comparator, ramp, wake, key; exp holds 0x01 to 0x04 in order.
	task automatic status_case(input logic [3:0] misc, input logic [15:0] gpi,
			input logic [3:0] lim, input logic [2:0] am, input logic [2:0] ah,
			input logic [31:0] exp);
		@(posedge core_clk_i);
		{comp_in, ramp_in, wake_in, key_n_in} <= misc;
		gpi_in <= gpi;
		lim_in <= lim;
		amode_in <= am;
		ahigh_in <= ah;
		rd_chk("misc status", 8'h01, exp[31:24]);
		rd_chk("inputs low status", 8'h02, exp[23:16]);
		rd_chk("inputs high status", 8'h03, exp[15:8]);
		rd_chk("limit status", 8'h04, exp[7:0]);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ==========================================================================
	// Scenarios
	// ==========================================================================
	initial begin
		logic ok;
		logic [15:0] pair;
		repeat (20) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		repeat (10) @(posedge core_clk_i);
		check_byte("config after reset", 8'h00, cfg());
		rd_chk("page control reset", 8'h00, 8'h00);
		wr(8'h00, 8'h7f);
		check_byte("config outputs", 8'h47, cfg());
		rd_chk("page control at 0x80", 8'h80, 8'h47);
		rd_chk("unmapped page read", 8'h01, 8'h00);
		wr(8'h80, 8'h00);
		check_byte("page zero again", 8'h00, cfg());
		host.write_frame(ADDR_W, 32'h00030507, 4, ok);
		check_bit("page write ack", 1'b1, ok);
		check_byte("page mode increments", 8'h03, cfg());
		wr(8'h00, 8'h40);
		host.write_frame(ADDR_W, 32'h01550042, 4, ok);
		check_byte("repeated mode pairs", 8'h42, cfg());
		wr(8'h00, 8'h81);
		check_byte("page held after own write", 8'h81, cfg());
		wr(8'h01, 8'h5a);
		check_byte("page returned", 8'h80, cfg());
		wr(8'h00, 8'h00);
		status_case(4'b1010, 16'ha53c, 4'b1010, 3'b000, 3'b000, 32'h0b3ca5a0);
		status_case(4'b0101, 16'h5ac3, 4'b0101, 3'b101, 3'b110, 32'h04c65a48);
		wr(8'h04, 8'hff);
		rd_chk("limit after write", 8'h04, 8'h48);
		host.read_pair(8'h03, pair);
		check_byte("first of two reads", 8'h5a, pair[15:8]);
		check_byte("read offset steps", 8'h48, pair[7:0]);
		test_done();
	end
	initial begin
		repeat (100000) @(posedge core_clk_i);
		num_errors++;
		$display("FAIL run length expected finish seen timeout");
		test_done();
	end
endmodule
